// File: ictl_motion_cfg_top.sv
// Register bank with lock-protected pointer, indirect data port and motion configuration
`timescale 1ns/1ps
`include "ictl_defs.svh"
module ictl_motion_cfg_top
  import ictl_pkg::*;
#(
  parameter int ACC_W = 11,
  parameter logic [7:0] LIMIT_RST = `ICTL_LIMIT_RST
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic SAMPLE_VALID_IN,
  input wire logic signed [ACC_W-1:0] ACCEL_Y_IN,
  input wire logic signed [ACC_W-1:0] ACCEL_X_IN,
  input wire logic signed [ACC_W-1:0] ACCEL_Z_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic LOCK_OPEN_OUT,
  output logic MOTION_TRIG_OUT,
  output logic [7:0] TWO_WIRE_CFG_OUT,
  output logic [7:0] OUT_CFG_OUT
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] pointer_r;
  logic [7:0] chan_logic_r;
  logic [7:0] y_limit_r;
  logic [7:0] x_limit_r;
  logic [7:0] z_limit_r;
  logic [7:0] two_wire_r;
  logic [7:0] out_cfg_r;
  logic [7:0] mode_r;
  logic [7:0] key_r;
  ictl_axes_t int_status_r;
  ictl_axes_t int_status_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic trig_r;
  logic lock_open_r;
  logic lock_open;

  // ----------------------------------------
  // Write and read decode
  // ----------------------------------------
  ictl_index_t index;
  logic idx_defined;
  logic wr_pointer;
  logic wr_data;
  logic wr_mode;
  logic wr_key;
  logic rd_status;
  logic wr_two_wire;
  logic wr_chan_logic;
  logic wr_y_limit;
  logic wr_x_limit;
  logic wr_z_limit;
  logic wr_out_cfg;
  logic [7:0] indirect_rd;
  logic [7:0] direct_rd;
  logic motion_hit;
  ictl_axes_t set_axes;

  assign index = pointer_r[4:0]; // [RQ1]
  assign idx_defined = (index == `ICTL_IDX_TWO_WIRE_OFF) || (index == `ICTL_IDX_CHAN_LOGIC) ||
                       (index == `ICTL_IDX_Y_LIMIT) || (index == `ICTL_IDX_X_LIMIT) ||
                       (index == `ICTL_IDX_Z_LIMIT) || (index == `ICTL_IDX_OUT_CFG); // [RQ1]

  assign wr_pointer = REG_WR_IN && (REG_ADDR_IN == `ICTL_ADDR_POINTER) && lock_open; // [RQ4]
  assign wr_data = REG_WR_IN && (REG_ADDR_IN == `ICTL_ADDR_DATA) && lock_open && idx_defined; // [RQ11]
  assign wr_mode = REG_WR_IN && (REG_ADDR_IN == `ICTL_ADDR_MODE);
  assign wr_key = REG_WR_IN && (REG_ADDR_IN == `ICTL_ADDR_UNLOCK);
  assign rd_status = REG_RD_IN && (REG_ADDR_IN == `ICTL_ADDR_INT_STATUS);

  assign wr_two_wire = wr_data && (index == `ICTL_IDX_TWO_WIRE_OFF); // [RQ13]
  assign wr_chan_logic = wr_data && (index == `ICTL_IDX_CHAN_LOGIC); // [RQ13]
  assign wr_y_limit = wr_data && (index == `ICTL_IDX_Y_LIMIT); // [RQ13]
  assign wr_x_limit = wr_data && (index == `ICTL_IDX_X_LIMIT); // [RQ13]
  assign wr_z_limit = wr_data && (index == `ICTL_IDX_Z_LIMIT); // [RQ13]
  assign wr_out_cfg = wr_data && (index == `ICTL_IDX_OUT_CFG); // [RQ13]

  // Selected indirect register, zero for a reserved index
  assign indirect_rd = (index == `ICTL_IDX_TWO_WIRE_OFF) ? two_wire_r :
                       (index == `ICTL_IDX_CHAN_LOGIC) ? chan_logic_r :
                       (index == `ICTL_IDX_Y_LIMIT) ? y_limit_r :
                       (index == `ICTL_IDX_X_LIMIT) ? x_limit_r :
                       (index == `ICTL_IDX_Z_LIMIT) ? z_limit_r :
                       (index == `ICTL_IDX_OUT_CFG) ? out_cfg_r : 8'h00; // [RQ3] [RQ11]

  assign direct_rd = (REG_ADDR_IN == `ICTL_ADDR_STATUS) ? {2'h0, lock_open, 5'h00} :
                     (REG_ADDR_IN == `ICTL_ADDR_MODE) ? mode_r :
                     (REG_ADDR_IN == `ICTL_ADDR_INT_STATUS) ? {5'h00, int_status_r} :
                     (REG_ADDR_IN == `ICTL_ADDR_POINTER) ? pointer_r :
                     (REG_ADDR_IN == `ICTL_ADDR_UNLOCK) ? key_r :
                     (REG_ADDR_IN == `ICTL_ADDR_DATA) ? indirect_rd : 8'h00;

  // ----------------------------------------
  // Lock sequencer
  // ----------------------------------------
  ictl_unlock_seq u_unlock (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .key_wr_in(wr_key),
    .key_in(REG_WDATA_IN),
    .lock_open_out(lock_open)
  );

  // ----------------------------------------
  // Motion comparator
  // ----------------------------------------
  ictl_motion_if #(.ACC_W(ACC_W)) mif (.clk(CORE_CLK_IN), .rst_n(RST_N_IN));

  assign mif.chan_logic = chan_logic_r;
  assign mif.y_limit = y_limit_r; // [RQ7]
  assign mif.x_limit = x_limit_r; // [RQ7]
  assign mif.z_limit = z_limit_r; // [RQ7]
  assign mif.active = (mode_r[2:0] == `ICTL_MODE_MOTION); // [RQ15]
  assign mif.acc_y = ACCEL_Y_IN;
  assign mif.acc_x = ACCEL_X_IN;
  assign mif.acc_z = ACCEL_Z_IN;

  ictl_motion_det #(.ACC_W(ACC_W)) u_det (
    .m(mif.det)
  );

  assign motion_hit = SAMPLE_VALID_IN && mif.trig; // [RQ12]
  assign set_axes = motion_hit ? (mif.hit & {chan_logic_r[`ICTL_EN_Y] | chan_logic_r[`ICTL_REQ_Y],
                                             chan_logic_r[`ICTL_EN_X] | chan_logic_r[`ICTL_REQ_X],
                                             chan_logic_r[`ICTL_EN_Z] | chan_logic_r[`ICTL_REQ_Z]})
                               : 3'h0; // [RQ16]
  // Reading clears, a new trigger in the same cycle wins
  assign int_status_nxt = (rd_status ? 3'h0 : int_status_r) | set_axes; // [RQ16]

  // ----------------------------------------
  // Direct registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      pointer_r <= 8'h00; // [RQ2]
      mode_r <= 8'h00;
      key_r <= 8'h00;
    end else begin
      if (wr_pointer) pointer_r <= REG_WDATA_IN; // [RQ1] [RQ4]
      if (wr_mode) mode_r <= REG_WDATA_IN & `ICTL_MODE_WMASK;
      if (wr_key) key_r <= REG_WDATA_IN; // [RQ14]
    end
  end

  // ----------------------------------------
  // Indirect registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      two_wire_r <= `ICTL_TWO_WIRE_RST;
      chan_logic_r <= `ICTL_CHAN_LOGIC_RST; // [RQ5] [RQ6]
      y_limit_r <= LIMIT_RST; // [RQ9]
      x_limit_r <= LIMIT_RST; // [RQ9]
      z_limit_r <= LIMIT_RST; // [RQ9]
      out_cfg_r <= `ICTL_OUT_CFG_RST;
    end else begin
      if (wr_two_wire) two_wire_r <= REG_WDATA_IN;
      if (wr_chan_logic) chan_logic_r <= {2'h0, REG_WDATA_IN[5:0]}; // [RQ5] [RQ6]
      if (wr_y_limit) y_limit_r <= REG_WDATA_IN; // [RQ7]
      if (wr_x_limit) x_limit_r <= REG_WDATA_IN; // [RQ7]
      if (wr_z_limit) z_limit_r <= REG_WDATA_IN; // [RQ7]
      if (wr_out_cfg) out_cfg_r <= {3'h0, REG_WDATA_IN[4:0]};
    end
  end

  // ----------------------------------------
  // Status, read port and outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      int_status_r <= 3'h0;
      trig_r <= 1'b0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      lock_open_r <= 1'b0;
    end else begin
      int_status_r <= int_status_nxt; // [RQ16]
      trig_r <= motion_hit; // [RQ8]
      rdata_r <= REG_RD_IN ? direct_rd : rdata_r; // [RQ3]
      rvalid_r <= REG_RD_IN;
      lock_open_r <= lock_open;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign REG_RVALID_OUT = rvalid_r;
  assign LOCK_OPEN_OUT = lock_open_r;
  assign MOTION_TRIG_OUT = trig_r;
  assign TWO_WIRE_CFG_OUT = two_wire_r;
  assign OUT_CFG_OUT = out_cfg_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ptr_reset_zero: assert property (@(posedge CORE_CLK_IN) // [RQ2]
    !RST_N_IN |=> pointer_r == 8'h00)
    else $error("pointer not zero after reset");

  a_ptr_load_open: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ1]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_POINTER && lock_open |=> pointer_r == $past(REG_WDATA_IN))
    else $error("pointer write lost while lock open");

  a_ptr_lock_gate: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ4]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_POINTER && !lock_open |=> $stable(pointer_r))
    else $error("pointer changed while lock closed");

  a_data_read_sel: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ3]
    REG_RD_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && index == `ICTL_IDX_Y_LIMIT
    |=> REG_RVALID_OUT && REG_RDATA_OUT == y_limit_r)
    else $error("data port did not show Y limit");

  a_rsvd_read_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ11]
    REG_RD_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && !idx_defined |=> REG_RDATA_OUT == 8'h00)
    else $error("reserved index read not zero");

  a_rsvd_write_drop: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ11]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && !idx_defined
    |=> $stable(chan_logic_r) && $stable(x_limit_r) && $stable(y_limit_r) && $stable(z_limit_r))
    else $error("reserved index write changed a register");

  a_data_write_x: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ13]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && lock_open && index == `ICTL_IDX_X_LIMIT
    |=> x_limit_r == $past(REG_WDATA_IN))
    else $error("X limit not written through data port");

  a_trig_needs_mode: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ15]
    MOTION_TRIG_OUT |-> $past(mode_r[2:0]) == `ICTL_MODE_MOTION)
    else $error("trigger outside motion mode");

  a_trig_axes_report: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ16]
    motion_hit && mif.hit[2] && chan_logic_r[`ICTL_EN_Y] |=> int_status_r[2] && MOTION_TRIG_OUT)
    else $error("Y trigger not reported");

  a_chan_rst_val: assert property (@(posedge CORE_CLK_IN) // [RQ5] [RQ6]
    !RST_N_IN |=> chan_logic_r == `ICTL_CHAN_LOGIC_RST)
    else $error("channel logic reset wrong");

  a_limit_rst_val: assert property (@(posedge CORE_CLK_IN) // [RQ9]
    !RST_N_IN |=> y_limit_r == LIMIT_RST && x_limit_r == LIMIT_RST && z_limit_r == LIMIT_RST)
    else $error("limit reset wrong");

  a_data_write_y: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ13]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && lock_open && index == `ICTL_IDX_Y_LIMIT
    |=> y_limit_r == $past(REG_WDATA_IN))
    else $error("Y limit write lost");

  a_data_write_z: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ13]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && lock_open && index == `ICTL_IDX_Z_LIMIT
    |=> z_limit_r == $past(REG_WDATA_IN))
    else $error("Z limit write lost");

  a_chan_write_mask: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ5] [RQ6]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && lock_open && index == `ICTL_IDX_CHAN_LOGIC
    |=> chan_logic_r == ($past(REG_WDATA_IN) & 8'h3f))
    else $error("channel logic write wrong");

  a_data_read_chan: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ3]
    REG_RD_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && index == `ICTL_IDX_CHAN_LOGIC
    |=> REG_RVALID_OUT && REG_RDATA_OUT == chan_logic_r)
    else $error("data port channel logic wrong");

  a_status_lock_bit: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ14]
    REG_RD_IN && REG_ADDR_IN == `ICTL_ADDR_STATUS |=> REG_RDATA_OUT == {2'h0, $past(lock_open), 5'h00})
    else $error("status lock bit wrong");

  a_lock_out_follow: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ14]
    1'b1 |-> LOCK_OPEN_OUT == $past(lock_open))
    else $error("lock output does not follow lock");

  a_trig_axes_x: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ16]
    motion_hit && mif.hit[1] && chan_logic_r[`ICTL_EN_X] |=> int_status_r[1])
    else $error("X trigger not reported");

  a_trig_axes_z: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ16]
    motion_hit && mif.hit[0] && chan_logic_r[`ICTL_EN_Z] |=> int_status_r[0])
    else $error("Z trigger not reported");

  a_no_trig_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ12]
    !SAMPLE_VALID_IN |=> !MOTION_TRIG_OUT)
    else $error("trigger without a sample");

  a_rvalid_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ3]
    1'b1 |-> REG_RVALID_OUT == $past(REG_RD_IN))
    else $error("read valid does not follow read");

  a_mode_write_mask: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // [RQ15]
    REG_WR_IN && REG_ADDR_IN == `ICTL_ADDR_MODE |=> mode_r == ($past(REG_WDATA_IN) & `ICTL_MODE_WMASK))
    else $error("mode write not masked");

  c_motion_trig: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) MOTION_TRIG_OUT);
  c_rsvd_read: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    REG_RD_IN && REG_ADDR_IN == `ICTL_ADDR_DATA && !idx_defined);
  c_and_trig: cover property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    motion_hit && chan_logic_r[`ICTL_REQ_X] && chan_logic_r[`ICTL_REQ_Y]);

endmodule : ictl_motion_cfg_top

// File: ictl_defs.svh
// Constants for the indirect control register bank and motion detector configuration
// Notes on behaviour
// (RQ1) Pointer index 4:0 selects indirect register; codes 01,02,03,04,05,0B defined, others reserved.
// (RQ2) Pointer resets to zero, bits 7:5 reserved, so no register selected.
// (RQ3) After pointer write, data port reads and writes the selected register.
// (RQ4) Pointer writes accepted only while lock open; host opens lock first.
// (RQ5) Channel logic bits 5,4,3 require Z, X, Y; AND of required, reset 0.
// (RQ6) Channel logic bits 2,1,0 enable Z, X, Y; OR of enabled, reset 1.
// (RQ7) One 8-bit threshold register per axis, compared during motion detection.
// (RQ8) Thresholds unsigned; axis magnitude reaching threshold triggers motion detector.
// (RQ9) Threshold reset value is 10h or 08h, chosen at build time.
// (RQ10) X and Z compare bits 5:0; Y compares bits 6:0.
// (RQ11) Reserved index: data port writes ignored, reads return zero.
// (RQ12) Trigger when one enabled channel hits and all required channels hit.
// (RQ13) Data port write stores its byte into the selected indirect register; channel logic keeps only bits 5:0 and output config only bits 4:0.
// (RQ14) Lock opens after key writes 00h, 50h, A0h; other sequences close it.
// (RQ15) Motion detection runs only while operation mode field holds 011.
// (RQ16) Trigger reports axes in status bits: 2 Y, 1 X, 0 Z.
`ifndef ICTL_DEFS_SVH
`define ICTL_DEFS_SVH

// ----------------------------------------
// Direct register addresses
// ----------------------------------------
`define ICTL_ADDR_STATUS 8'h02
`define ICTL_ADDR_MODE 8'h14
`define ICTL_ADDR_INT_STATUS 8'h16
`define ICTL_ADDR_POINTER 8'h18
`define ICTL_ADDR_UNLOCK 8'h1e
`define ICTL_ADDR_DATA 8'h22

// ----------------------------------------
// Indirect indexes
// ----------------------------------------
`define ICTL_IDX_TWO_WIRE_OFF 5'h01
`define ICTL_IDX_CHAN_LOGIC 5'h02
`define ICTL_IDX_Y_LIMIT 5'h03
`define ICTL_IDX_X_LIMIT 5'h04
`define ICTL_IDX_Z_LIMIT 5'h05
`define ICTL_IDX_OUT_CFG 5'h0b

// ----------------------------------------
// Fields, keys and reset values
// ----------------------------------------
`define ICTL_KEY_FIRST 8'h00
`define ICTL_KEY_SECOND 8'h50
`define ICTL_KEY_THIRD 8'ha0
`define ICTL_MODE_MOTION 3'h3
`define ICTL_MODE_WMASK 8'hd7
`define ICTL_LOCK_BIT 5
`define ICTL_REQ_Z 5
`define ICTL_REQ_X 4
`define ICTL_REQ_Y 3
`define ICTL_EN_Z 2
`define ICTL_EN_X 1
`define ICTL_EN_Y 0
`define ICTL_CHAN_LOGIC_RST 8'h07
`define ICTL_OUT_CFG_RST 8'h1c
`define ICTL_TWO_WIRE_RST 8'h00
`define ICTL_LIMIT_RST 8'h10
`define ICTL_XZ_LIMIT_MASK 8'h3f
`define ICTL_Y_LIMIT_MASK 8'h7f

`endif

// File: ictl_pkg.sv
// Types shared by the indirect control register bank
package ictl_pkg;

  typedef enum logic [1:0] {LK_CLOSED, LK_KEY0, LK_KEY1, LK_OPEN} ictl_lock_t;

  typedef logic [4:0] ictl_index_t;

  typedef logic [2:0] ictl_axes_t;

endpackage : ictl_pkg

// File: ictl_motion_if.sv
// Interface between the register bank and the motion comparator
`timescale 1ns/1ps
interface ictl_motion_if #(parameter int ACC_W = 11) (input wire logic clk, input wire logic rst_n);
  logic [7:0] chan_logic;
  logic [7:0] y_limit;
  logic [7:0] x_limit;
  logic [7:0] z_limit;
  logic active;
  logic signed [ACC_W-1:0] acc_y;
  logic signed [ACC_W-1:0] acc_x;
  logic signed [ACC_W-1:0] acc_z;
  logic [2:0] hit;
  logic trig;

  modport cfg (
    input clk, rst_n, hit, trig,
    output chan_logic, y_limit, x_limit, z_limit, active, acc_y, acc_x, acc_z
  );

  modport det (
    input clk, rst_n, chan_logic, y_limit, x_limit, z_limit, active, acc_y, acc_x, acc_z,
    output hit, trig
  );
endinterface : ictl_motion_if

// File: ictl_unlock_seq.sv
// Key sequencer that opens and closes the register lock
`timescale 1ns/1ps
`include "ictl_defs.svh"
module ictl_unlock_seq
  import ictl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_in,
  output logic lock_open_out
);

  ictl_lock_t state_r;
  ictl_lock_t state_nxt;

  // ----------------------------------------
  // Sequence tracking
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (key_wr_in) begin
      unique case (state_r)
        LK_KEY0: state_nxt = (key_in == `ICTL_KEY_SECOND) ? LK_KEY1 :
                             (key_in == `ICTL_KEY_FIRST) ? LK_KEY0 : LK_CLOSED; // [RQ14]
        LK_KEY1: state_nxt = (key_in == `ICTL_KEY_THIRD) ? LK_OPEN :
                             (key_in == `ICTL_KEY_FIRST) ? LK_KEY0 : LK_CLOSED; // [RQ14]
        LK_CLOSED, LK_OPEN: state_nxt = (key_in == `ICTL_KEY_FIRST) ? LK_KEY0 : LK_CLOSED; // [RQ14]
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) state_r <= LK_CLOSED;
    else state_r <= state_nxt;
  end

  assign lock_open_out = (state_r == LK_OPEN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_key_seq_opens: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ14]
    (key_wr_in && key_in == `ICTL_KEY_FIRST) ##1 (key_wr_in && key_in == `ICTL_KEY_SECOND)
    ##1 (key_wr_in && key_in == `ICTL_KEY_THIRD) |=> lock_open_out)
    else $error("lock did not open after key sequence");

  a_bad_key_closes: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ14]
    key_wr_in && key_in != `ICTL_KEY_SECOND && key_in != `ICTL_KEY_THIRD |=> !lock_open_out)
    else $error("lock stayed open after a foreign key");

  c_lock_opened: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(lock_open_out));

endmodule : ictl_unlock_seq

// File: ictl_motion_det.sv
// Per-axis threshold comparison and channel trigger logic
`timescale 1ns/1ps
`include "ictl_defs.svh"
module ictl_motion_det
  import ictl_pkg::*;
#(
  parameter int ACC_W = 11
) (
  ictl_motion_if.det m
);

  logic signed [ACC_W-1:0] acc_all [3];
  logic [7:0] lim_all [3];
  logic [ACC_W-1:0] mag [3];
  ictl_axes_t req_yxz;
  ictl_axes_t en_yxz;

  // ----------------------------------------
  // Axis order: 2 Y, 1 X, 0 Z
  // ----------------------------------------
  assign acc_all[2] = m.acc_y;
  assign acc_all[1] = m.acc_x;
  assign acc_all[0] = m.acc_z;
  assign lim_all[2] = m.y_limit & `ICTL_Y_LIMIT_MASK; // [RQ10]
  assign lim_all[1] = m.x_limit & `ICTL_XZ_LIMIT_MASK; // [RQ10]
  assign lim_all[0] = m.z_limit & `ICTL_XZ_LIMIT_MASK; // [RQ10]
  assign req_yxz = {m.chan_logic[`ICTL_REQ_Y], m.chan_logic[`ICTL_REQ_X], m.chan_logic[`ICTL_REQ_Z]}; // [RQ5]
  assign en_yxz = {m.chan_logic[`ICTL_EN_Y], m.chan_logic[`ICTL_EN_X], m.chan_logic[`ICTL_EN_Z]}; // [RQ6]

  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign mag[i] = acc_all[i][ACC_W-1] ? (~acc_all[i] + 1'b1) : acc_all[i];
    assign m.hit[i] = (mag[i] >= {{(ACC_W-8){1'b0}}, lim_all[i]}); // [RQ8]
  end

  // One enabled axis hits and every required axis hits, only in motion mode
  assign m.trig = m.active && (|(m.hit & en_yxz)) && (&(m.hit | ~req_yxz)); // [RQ12] [RQ15]

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_req_and_hold: assert property (@(posedge m.clk) disable iff (!m.rst_n) // [RQ5]
    m.trig && m.chan_logic[`ICTL_REQ_X] |-> mag[1] >= {{(ACC_W-8){1'b0}}, m.x_limit & `ICTL_XZ_LIMIT_MASK})
    else $error("trigger without required X hit");

  a_en_or_hit: assert property (@(posedge m.clk) disable iff (!m.rst_n) // [RQ6]
    m.active && m.chan_logic[`ICTL_EN_Y] && m.chan_logic[5:3] == 3'h0 &&
    mag[2] >= {{(ACC_W-8){1'b0}}, m.y_limit & `ICTL_Y_LIMIT_MASK} |-> m.trig)
    else $error("enabled Y hit did not trigger");

  a_idle_no_trig: assert property (@(posedge m.clk) disable iff (!m.rst_n) // [RQ15]
    !m.active |-> !m.trig)
    else $error("trigger outside motion mode");

endmodule : ictl_motion_det

// File: ictl_host_model.sv
// Host controller model driving the register port of the configuration bank
`timescale 1ns/1ps
module ictl_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  // ----------------------------------------
  // Register port cycles
  // ----------------------------------------
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    v = rvalid_in;
    d = rdata_in;
  endtask : rd_reg

  // ----------------------------------------
  // Host sequences
  // ----------------------------------------
  task automatic unlock();
    wr_reg(8'h1e, 8'h00);
    wr_reg(8'h1e, 8'h50);
    wr_reg(8'h1e, 8'ha0);
  endtask : unlock

  task automatic select(input logic [4:0] idx);
    wr_reg(8'h18, {3'h0, idx});
  endtask : select

  task automatic put_data(input logic [7:0] d);
    wr_reg(8'h22, d);
  endtask : put_data
endmodule : ictl_host_model

// File: ictl_motion_cfg_top_tb.sv
// Self-checking testbench for the indirect register bank and motion configuration
`timescale 1ns/1ps
module ictl_motion_cfg_top_tb;
  import ictl_pkg::*;
  localparam int ACC_W = 11;
  localparam logic [7:0] LIMIT = 8'h08;
  logic core_clk, rst_n, sample_valid;
  logic signed [ACC_W-1:0] acc_y, acc_x, acc_z;
  logic wr, rd, rvalid, lock_open, trig;
  logic [7:0] addr, wdata, rdata, two_wire, out_cfg;
  int bad_count = 0;
  int compares = 0;
  logic [4:0] idx_tab [6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0b};
  logic [7:0] rst_tab [6] = '{8'h00, 8'h07, LIMIT, LIMIT, LIMIT, 8'h1c};
  logic [7:0] wr_tab [6] = '{8'ha5, 8'hff, 8'hc3, 8'h96, 8'h5a, 8'hff};
  logic [7:0] rb_tab [6] = '{8'ha5, 8'h3f, 8'hc3, 8'h96, 8'h5a, 8'h1f};
  logic [4:0] rsv_tab [5] = '{5'h00, 5'h06, 5'h0a, 5'h0c, 5'h1f};
  logic [7:0] mode_tab [4] = '{8'h00, 8'h01, 8'h02, 8'hff};

  ictl_motion_cfg_top #(.ACC_W(ACC_W), .LIMIT_RST(LIMIT)) u_ictl_motion_cfg_top (
    .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .SAMPLE_VALID_IN(sample_valid),
    .ACCEL_Y_IN(acc_y), .ACCEL_X_IN(acc_x), .ACCEL_Z_IN(acc_z),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .LOCK_OPEN_OUT(lock_open),
    .MOTION_TRIG_OUT(trig), .TWO_WIRE_CFG_OUT(two_wire), .OUT_CFG_OUT(out_cfg));

  ictl_host_model u_ictl_host_model (
    .clk_in(core_clk), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_ictl_host_model.rd_reg(a, d, v);
    chk_bit(v, 1'b1);
    chk(d, exp);
  endtask : rd_chk

  task automatic ind_set(input logic [4:0] idx, input logic [7:0] val);
    u_ictl_host_model.select(idx);
    u_ictl_host_model.put_data(val);
  endtask : ind_set

  task automatic ind_chk(input logic [4:0] idx, input logic [7:0] exp);
    u_ictl_host_model.select(idx);
    rd_chk(8'h22, exp);
  endtask : ind_chk

  task automatic samp(input int y, input int x, input int z, input logic exp);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    acc_y <= ACC_W'(y);
    acc_x <= ACC_W'(x);
    acc_z <= ACC_W'(z);
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1;
    chk_bit(trig, exp);
  endtask : samp

  task automatic end_sim();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    acc_y = '0;
    acc_x = '0;
    acc_z = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(two_wire, 8'h00);
    chk(out_cfg, 8'h1c);
    chk_bit(lock_open, 1'b0);
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h22, 8'h00);
    u_ictl_host_model.select(5'h02);
    rd_chk(8'h18, 8'h00);
    u_ictl_host_model.unlock();
    rd_chk(8'h02, 8'h20);
    chk_bit(lock_open, 1'b1);
    for (int i = 0; i < 6; i++) begin
      ind_chk(idx_tab[i], rst_tab[i]);
      ind_set(idx_tab[i], wr_tab[i]);
      rd_chk(8'h22, rb_tab[i]);
    end
    chk(two_wire, 8'ha5);
    chk(out_cfg, 8'h1f);
    for (int i = 0; i < 5; i++) begin
      ind_set(rsv_tab[i], 8'h55);
      rd_chk(8'h22, 8'h00);
    end
    u_ictl_host_model.wr_reg(8'h18, 8'he6);
    rd_chk(8'h18, 8'he6);
    rd_chk(8'h22, 8'h00);
    ind_chk(5'h04, 8'h96);
    u_ictl_host_model.wr_reg(8'h1e, 8'h11);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h1e, 8'h11);
    u_ictl_host_model.put_data(8'h3c);
    u_ictl_host_model.select(5'h05);
    rd_chk(8'h18, 8'h04);
    u_ictl_host_model.unlock();
    rd_chk(8'h22, 8'h96);
    u_ictl_host_model.wr_reg(8'h40, 8'h77);
    rd_chk(8'h40, 8'h00);
    u_ictl_host_model.wr_reg(8'h14, 8'h03);
    ind_set(5'h04, 8'h10);
    ind_set(5'h03, 8'hff);
    ind_set(5'h05, 8'hd0);
    ind_set(5'h02, 8'h02);
    samp(0, 16, 0, 1'b1);
    rd_chk(8'h16, 8'h02);
    rd_chk(8'h16, 8'h00);
    samp(0, 15, 0, 1'b0);
    samp(0, -16, 0, 1'b1);
    ind_set(5'h02, 8'h01);
    samp(126, 0, 0, 1'b0);
    samp(127, 0, 0, 1'b1);
    rd_chk(8'h16, 8'h06);
    ind_set(5'h02, 8'h04);
    samp(0, 0, 16, 1'b1);
    rd_chk(8'h16, 8'h01);
    ind_set(5'h02, 8'h1b);
    samp(0, 16, 0, 1'b0);
    samp(127, 16, 0, 1'b1);
    rd_chk(8'h16, 8'h06);
    ind_set(5'h02, 8'h00);
    samp(127, 16, 16, 1'b0);
    ind_set(5'h02, 8'h07);
    for (int i = 0; i < 4; i++) begin
      u_ictl_host_model.wr_reg(8'h14, mode_tab[i]);
      samp(127, 16, 16, 1'b0);
    end
    rd_chk(8'h14, 8'hd7);
    u_ictl_host_model.wr_reg(8'h14, 8'h03);
    samp(127, 16, 16, 1'b1);
    end_sim();
  end
endmodule : ictl_motion_cfg_top_tb
